//--- rtl/acs_consts.vh
/*
  Constants for the converter channel sequencer: control word field
  positions, reset values, input types and negative input selector codes.
  Assumes it is included by bare name from the design files.
*/
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH

// Control word layout and reset value.
`define ACS_CTRL_W 12
`define ACS_CTRL_RST 12'h000
`define ACS_ADDR_HI 7
`define ACS_ADDR_LO 5
`define ACS_TYPE1_BIT 4
`define ACS_TYPE0_BIT 3
`define ACS_ALT_BIT 2
`define ACS_CYC_BIT 1

// Mask register width and reset value.
`define ACS_MASK_W 8
`define ACS_MASK_RST 8'h00

// Input types, coded {input_type_bit1, input_type_bit0}.
`define ACS_TYPE_SE 2'h0
`define ACS_TYPE_DIFF 2'h2
`define ACS_TYPE_PSD1 2'h1
`define ACS_TYPE_PSD2 2'h3

// Negative input selector codes: 0..7 analog inputs, 8 analog ground.
`define ACS_NEG_GND 4'h8
`define ACS_COMMON_NEG 4'h7

`endif

//--- rtl/acs_pair_decode.v
/*
  Decodes an input type and a three-bit channel address into the
  positive and negative input selectors of the multiplexer.
  Assumes inputs and outputs stay in the sys_clk domain; outputs are
  combinational and registered by the instantiating module.
*/
`timescale 1ns/1ns
`include "acs_consts.vh"

module acs_pair_decode (
  // Selection
  input wire [1:0] in_type,
  input wire [2:0] chan,
  // Multiplexer selectors
  output reg [3:0] pos_sel,
  output reg [3:0] neg_sel
);

  // Single-ended uses ground, pairs flip the low address bit, and the
  // seven-input type refers every input to the common one.
  always @* begin
    pos_sel = {1'b0, chan};
    neg_sel = `ACS_NEG_GND;
    case (in_type)
      `ACS_TYPE_SE: neg_sel = `ACS_NEG_GND;
      `ACS_TYPE_DIFF: neg_sel = {1'b0, chan[2:1], ~chan[0]};
      `ACS_TYPE_PSD1: neg_sel = {1'b0, chan[2:1], ~chan[0]};
      `ACS_TYPE_PSD2: neg_sel = `ACS_COMMON_NEG;
      default: neg_sel = `ACS_NEG_GND;
    endcase
  end

endmodule // acs_pair_decode

//--- rtl/acs_sequencer.v
/*
  Channel selection and sequencer of an eight-input converter. Holds
  the 12-bit control word and the 8-bit channel mask, written over a
  parallel bus with chip select and write strobe, and steps channels on
  each falling edge of the conversion start input.

  Control word fields: channel address in bits 7 to 5, input type in
  bits 4 and 3, alternate select in bit 2 and cycling enable in bit 1.
  The remaining bits are stored and handed on, but not decoded here.

  Sequencer modes, coded {cycling enable, alternate select}:
    00  no sequence; each trigger converts the last written address.
    01  arm the mask; the very next write lands in the channel mask and
        starts a mask sequence from its lowest selected channel.
    10  keep running; the rest of the word is updated in place.
    11  consecutive run from channel 0 up to the written address.

  Paired input types never convert the swapped orientation in a sequence, unless a keep-running
  write switches a consecutive run standing on an odd channel to a paired type: odd mask
  bits are ignored and a consecutive run steps two channels at a time.

  Timing: strobe, select and trigger cross three flops, the bus two, so a
  strobe or trigger edge acts on about the fourth sys_clk edge after it.
  The selectors follow one cycle after conv_chan_q. A trigger that is
  seen in the same cycle as a write is held for one cycle and served
  right after the write, so no conversion is lost to a collision.

  Limitations: an empty effective mask gives no conversion start, and
  address 7 in the seven-input type still selects input 7 as positive;
  the host must avoid both.

  Assumes the bus and trigger pins are asynchronous to sys_clk and are
  held stable for several sys_clk periods around each strobe edge, and
  that strobe and trigger stay low and high for at least four periods.
*/
`timescale 1ns/1ns
`include "acs_consts.vh"

module acs_sequencer (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Parallel bus pins
  input wire chip_select_n,
  input wire store_strobe_n,
  input wire [11:0] bus_data,
  // Conversion start pin
  input wire conv_trigger_n,
  // Multiplexer selection for the conversion core
  output reg [3:0] pos_sel_q,
  output reg [3:0] neg_sel_q,
  output reg [2:0] conv_chan_q,
  output reg conv_start_q,
  // State for software-visible status and the core
  output reg [11:0] ctrl_word_q,
  output reg [7:0] chan_mask_q,
  output reg seq_active_q
);

  // Sequence kinds held while running.
  localparam KIND_MASK = 1'b0;
  localparam KIND_CONSEC = 1'b1;

  // Three-stage synchronisers for control pins, two-stage for the bus; only the last stage is read.
  reg [1:0] cs_meta_q;
  reg [1:0] wr_meta_q;
  reg [1:0] cv_meta_q;
  reg [11:0] dat_meta_q;
  reg [11:0] dat_sync_q;
  reg cs_sync_q;
  reg wr_sync_q;
  reg cv_sync_q;
  reg wr_prev_q;
  reg cv_prev_q;

  // Sequencer state.
  reg mask_armed_q;
  reg seq_kind_q;
  reg [2:0] last_chan_q;
  reg [2:0] cur_chan_q;
  reg cv_pend_q;

  wire wr_rise;
  wire cv_fall;
  wire [2:0] wr_addr;
  wire wr_cyc;
  wire wr_alt;
  wire [1:0] cur_type;
  wire paired;
  wire [7:0] eff_mask;
  reg [2:0] next_chan;
  reg next_found;
  reg [2:0] first_chan;
  reg first_found;
  wire [3:0] dec_pos;
  wire [3:0] dec_neg;
  wire [3:0] consec_step;
  wire cv_take;
  integer i;

  // Control pins cross three flops and the bus two before any logic looks at them.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cs_meta_q <= 2'h3; // Idle high, so no false edge follows reset.
      wr_meta_q <= 2'h3;
      cv_meta_q <= 2'h3;
      dat_meta_q <= 12'h000;
      dat_sync_q <= 12'h000;
      cs_sync_q <= 1'b1;
      wr_sync_q <= 1'b1;
      cv_sync_q <= 1'b1;
      wr_prev_q <= 1'b1;
      cv_prev_q <= 1'b1;
    end else begin
      cs_meta_q <= {cs_meta_q[0], chip_select_n};
      wr_meta_q <= {wr_meta_q[0], store_strobe_n};
      cv_meta_q <= {cv_meta_q[0], conv_trigger_n};
      dat_meta_q <= bus_data;
      dat_sync_q <= dat_meta_q;
      cs_sync_q <= cs_meta_q[1];
      wr_sync_q <= wr_meta_q[1];
      cv_sync_q <= cv_meta_q[1];
      wr_prev_q <= wr_sync_q;
      cv_prev_q <= cv_sync_q;
    end
  end

  // A write completes on the strobe rising edge while selected.
  assign wr_rise = wr_sync_q & ~wr_prev_q & ~cs_sync_q;
  assign cv_fall = ~cv_sync_q & cv_prev_q;
  assign wr_addr = dat_sync_q[`ACS_ADDR_HI:`ACS_ADDR_LO];
  assign wr_cyc = dat_sync_q[`ACS_CYC_BIT];
  assign wr_alt = dat_sync_q[`ACS_ALT_BIT];
  assign cur_type = {ctrl_word_q[`ACS_TYPE1_BIT],
                     ctrl_word_q[`ACS_TYPE0_BIT]};
  assign paired = (cur_type == `ACS_TYPE_DIFF) ||
                  (cur_type == `ACS_TYPE_PSD1);

  // A trigger held back by a colliding write is served one cycle late.
  assign cv_take = cv_fall | cv_pend_q;
  // Paired types step a whole pair so, from an even channel, the odd channel is never positive.
  assign consec_step = {1'b0, cur_chan_q} + (paired ? 4'h2 : 4'h1);

  // Mask bit n enables input n; paired types keep only even channels so
  // the swapped orientation is never reached.
  genvar g;
  generate
    for (g = 0; g < `ACS_MASK_W; g = g + 1) begin : g_mask
      if (g % 2 == 1) begin : g_odd
        assign eff_mask[g] = chan_mask_q[g] & ~paired;
      end else begin : g_even
        assign eff_mask[g] = chan_mask_q[g];
      end
    end
  endgenerate

  // Find the next selected channel above the current one, and the lowest
  // selected channel for the wrap. Loop from the top so the lowest wins.
  always @* begin
    next_chan = 3'h0;
    next_found = 1'b0;
    first_chan = 3'h0;
    first_found = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (eff_mask[i]) begin
        first_chan = i[2:0];
        first_found = 1'b1;
        if (i[2:0] > cur_chan_q) begin
          next_chan = i[2:0];
          next_found = 1'b1;
        end
      end
    end
  end

  // Control, mask and sequence state. A write while the mask is armed
  // goes to the mask; any other write goes to the control word.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_word_q <= `ACS_CTRL_RST;
      chan_mask_q <= `ACS_MASK_RST;
      mask_armed_q <= 1'b0;
      seq_active_q <= 1'b0;
      seq_kind_q <= KIND_MASK;
      last_chan_q <= 3'h0;
      cur_chan_q <= 3'h7;
      conv_chan_q <= 3'h0;
      conv_start_q <= 1'b0;
      cv_pend_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      cv_pend_q <= 1'b0;
      if (wr_rise && mask_armed_q) begin
        chan_mask_q <= dat_sync_q[7:0];
        cv_pend_q <= cv_take;
        mask_armed_q <= 1'b0;
        seq_active_q <= 1'b1;
        seq_kind_q <= KIND_MASK;
        cur_chan_q <= 3'h7; // Next trigger starts at the lowest bit.
      end else if (wr_rise) begin
        ctrl_word_q <= dat_sync_q;
        cv_pend_q <= cv_take;
        mask_armed_q <= ~wr_cyc & wr_alt;
        if (wr_cyc && !wr_alt) begin
          seq_active_q <= seq_active_q;
        end else if (wr_cyc && wr_alt) begin
          seq_active_q <= 1'b1;
          seq_kind_q <= KIND_CONSEC;
          last_chan_q <= wr_addr;
          cur_chan_q <= wr_addr; // Wraps to channel 0 on first trigger.
        end else begin
          seq_active_q <= 1'b0;
        end
      end else if (cv_take) begin
        conv_start_q <= 1'b1;
        if (!seq_active_q) begin
          conv_chan_q <= ctrl_word_q[`ACS_ADDR_HI:`ACS_ADDR_LO];
        end else if (seq_kind_q == KIND_CONSEC) begin
          if (consec_step > {1'b0, last_chan_q}) begin
            cur_chan_q <= 3'h0;
            conv_chan_q <= 3'h0;
          end else begin
            cur_chan_q <= consec_step[2:0];
            conv_chan_q <= consec_step[2:0];
          end
        end else if (next_found) begin
          cur_chan_q <= next_chan;
          conv_chan_q <= next_chan;
        end else begin
          cur_chan_q <= first_chan;
          conv_chan_q <= first_chan;
          conv_start_q <= first_found;
        end
      end
    end
  end

  acs_pair_decode u_dec (
    .in_type(cur_type),
    .chan(conv_chan_q),
    .pos_sel(dec_pos),
    .neg_sel(dec_neg)
  );

  // Register the multiplexer selectors so the outputs come from flops.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pos_sel_q <= 4'h0;
      neg_sel_q <= `ACS_NEG_GND;
    end else begin
      pos_sel_q <= dec_pos;
      neg_sel_q <= dec_neg;
    end
  end

endmodule // acs_sequencer

//--- dv/acs_host_model.sv
/*
  Host model: drives the bus and trigger pins of the sequencer.
  Assumes its tasks are called from one bench process only.
*/
`timescale 1ns/1ns
module acs_host_model (
  // Clock
  input wire sys_clk,
  // Pins towards the device
  output logic chip_select_n,
  output logic store_strobe_n,
  output logic [11:0] bus_data,
  output logic conv_trigger_n
);
  // All pins idle high or zero before the first cycle.
  initial begin
    chip_select_n = 1'b1;
    store_strobe_n = 1'b1;
    bus_data = 12'h000;
    conv_trigger_n = 1'b1;
  end
  // One write; stale data is inverted so a late sample cannot match.
  task automatic wr(input logic [11:0] d, input logic cs_n);
    @(posedge sys_clk) #1;
    chip_select_n = cs_n;
    bus_data = d;
    repeat (4) @(posedge sys_clk);
    #1 store_strobe_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 store_strobe_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chip_select_n = 1'b1;
    bus_data = ~d;
    repeat (6) @(posedge sys_clk);
  endtask
  // One conversion start, low and high long enough to be seen.
  task automatic trig();
    @(posedge sys_clk) #1;
    conv_trigger_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 conv_trigger_n = 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule // acs_host_model

//--- dv/acs_sequencer_monitor.sv
/*
  Checker of the sequencer outputs.
  Assumes it is bound to the design and sees only its ports.
*/
`timescale 1ns/1ns
module acs_sequencer_monitor (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Outputs
  input wire [3:0] pos_sel_q,
  input wire [3:0] neg_sel_q,
  input wire [2:0] conv_chan_q,
  input wire conv_start_q,
  input wire [11:0] ctrl_word_q,
  input wire [7:0] chan_mask_q,
  input wire seq_active_q
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Type and sequencer fields of the live control word.
  wire [1:0] ty = ctrl_word_q[4:3];
  wire [1:0] sq = ctrl_word_q[2:1];
  wire [3:0] ch = {1'b0, conv_chan_q};
  property p_rst;
    $rose(rst_n) |-> ctrl_word_q == 12'h000 && chan_mask_q == 8'h00
      && !seq_active_q && neg_sel_q == 4'h8;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_se;
    conv_start_q && ty == 2'h0 |=> pos_sel_q == $past(ch)
      && neg_sel_q == 4'h8;
  endproperty
  a_se: assert property (p_se) else $error("bad single");
  property p_pair;
    conv_start_q && ^ty |=> pos_sel_q == $past(ch)
      && neg_sel_q == ($past(ch) ^ 4'h1);
  endproperty
  a_pair: assert property (p_pair) else $error("bad pair");
  property p_com;
    conv_start_q && ty == 2'h3 |=> pos_sel_q == $past(ch)
      && neg_sel_q == 4'h7;
  endproperty
  a_com: assert property (p_com) else $error("bad common");
  property p_even;
    conv_start_q && seq_active_q && ^ty |-> !conv_chan_q[0];
  endproperty
  a_even: assert property (p_even) else $error("odd pair");
  property p_mask;
    conv_start_q && seq_active_q && sq == 2'h2 |-> chan_mask_q[conv_chan_q];
  endproperty
  a_mask: assert property (p_mask) else $error("unmasked");
  property p_run;
    conv_start_q && sq == 2'h3 |-> conv_chan_q <= ctrl_word_q[7:5];
  endproperty
  a_run: assert property (p_run) else $error("past final");
  property p_off;
    conv_start_q && sq == 2'h0 |-> !seq_active_q
      && conv_chan_q == ctrl_word_q[7:5];
  endproperty
  a_off: assert property (p_off) else $error("bad off");
  property p_pulse;
    conv_start_q |=> !conv_start_q;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long start");
endmodule // acs_sequencer_monitor
bind acs_sequencer acs_sequencer_monitor u_mon (.sys_clk, .rst_n,
  .pos_sel_q, .neg_sel_q, .conv_chan_q, .conv_start_q, .ctrl_word_q,
  .chan_mask_q, .seq_active_q);

//--- dv/tb_acs_sequencer.sv
/*
  Self-checking bench for the channel sequencer.
  Assumes the host model drives the bus and trigger pins; the bench drives reset and watches outputs.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
  failures++; $display("MISMATCH %0t %h %h", $time, a, e); end end
module tb_acs_sequencer;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  wire chip_select_n, store_strobe_n, conv_trigger_n;
  wire [11:0] bus_data, ctrl_word_q;
  wire [3:0] pos_sel_q, neg_sel_q;
  wire [2:0] conv_chan_q;
  wire [7:0] chan_mask_q;
  wire conv_start_q, seq_active_q;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int starts = 0;
  logic [2:0] got_chan;
  always #5 sys_clk = ~sys_clk;
  acs_host_model u_host (.sys_clk, .chip_select_n, .store_strobe_n,
    .bus_data, .conv_trigger_n);
  acs_sequencer u_dut (.sys_clk, .rst_n, .chip_select_n, .store_strobe_n,
    .bus_data, .conv_trigger_n, .pos_sel_q, .neg_sel_q, .conv_chan_q,
    .conv_start_q, .ctrl_word_q, .chan_mask_q, .seq_active_q);
  // Sample on the falling edge, where registered outputs have settled.
  always @(negedge sys_clk) begin
    cyc++;
    if (conv_start_q === 1'b1) begin
      starts++;
      got_chan = conv_chan_q;
    end
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One trigger must give exactly one start on the expected channel.
  task automatic conv(input logic [2:0] c, input logic [3:0] n);
    int s;
    s = starts;
    u_host.trig();
    `CHK(starts - s, 1)
    `CHK(got_chan, c)
    `CHK(pos_sel_q, {1'b0, c})
    `CHK(neg_sel_q, n)
  endtask
  task automatic t_reset();
    `CHK({ctrl_word_q, chan_mask_q, neg_sel_q}, 24'h0000_08)
  endtask
  // Every input type and address with the sequencer off, except address 7 in the seven-input type.
  task automatic t_types();
    logic [11:0] w;
    for (int t = 0; t < 4; t++)
      for (int a = 0; a < 8; a++) begin
        if (t == 3 && a == 7) continue;
        w = {4'h0, a[2:0], t[1:0], 3'h0};
        u_host.wr(w, 1'b0);
        `CHK(ctrl_word_q, w)
        conv(a[2:0], t == 0 ? 4'h8 : t == 3 ? 4'h7 :
          {1'b0, a[2:0] ^ 3'h1});
      end
  endtask
  // Mask sequence with wrap, a keep-running write, then a stop.
  task automatic t_mask();
    logic [2:0] ord [5] = '{3'd0, 3'd2, 3'd5, 3'd7, 3'd0};
    u_host.wr(12'h004, 1'b0);
    u_host.wr(12'h0A5, 1'b0);
    `CHK({ctrl_word_q, chan_mask_q, seq_active_q}, 21'h0_094B)
    foreach (ord[i]) conv(ord[i], 4'h8);
    u_host.wr(12'h0E2, 1'b0);
    conv(3'd2, 4'h8);
    u_host.wr(12'h0E0, 1'b0);
    `CHK(seq_active_q, 1'b0)
    conv(3'd7, 4'h8);
  endtask
  // Strobe without select is ignored; the write after a mask write lands
  // in the control word and keeps the new mask sequence running.
  task automatic t_refuse();
    u_host.wr(12'h123, 1'b1);
    `CHK(ctrl_word_q, 12'h0E0)
    u_host.wr(12'h004, 1'b0);
    u_host.wr(12'h060, 1'b0);
    u_host.wr(12'h033, 1'b0);
    `CHK({ctrl_word_q, chan_mask_q}, 20'h0_3360)
    `CHK(seq_active_q, 1'b1)
  endtask
  // Paired mask and consecutive runs, then a single-ended consecutive run.
  task automatic t_pair();
    u_host.wr(12'h014, 1'b0);
    `CHK(seq_active_q, 1'b0)
    u_host.wr(12'h00F, 1'b0);
    conv(3'd0, 4'h1);
    conv(3'd2, 4'h3);
    conv(3'd0, 4'h1);
    u_host.wr(12'h076, 1'b0);
    conv(3'd0, 4'h1);
    conv(3'd2, 4'h3);
    conv(3'd0, 4'h1);
    u_host.wr(12'h066, 1'b0);
    for (int i = 0; i < 5; i++) conv(3'(i % 4), 4'h8);
  endtask
  // A reset in mid-run clears all state and leaves no false trigger.
  task automatic t_rerst();
    int s;
    s = starts;
    @(posedge sys_clk) #1 rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge sys_clk);
    `CHK({ctrl_word_q, chan_mask_q, seq_active_q}, 21'h0_0000)
    `CHK(neg_sel_q, 4'h8)
    `CHK(starts - s, 0)
    conv(3'd0, 4'h8);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_types();
    t_mask();
    t_refuse();
    t_pair();
    t_rerst();
    report_and_stop();
  end
endmodule // tb_acs_sequencer
